// ---- mfpc_front_panel.sv ----
/*
 * Front panel control for an energy meter: buttons, display modes,
 * screen scrolling, contrast, demand reset with lockout, pulser
 * mirroring, status bar and numeric slot formatting.
 * Assumes buttons are raw active-high pins from outside the clock domain;
 * metering values, clock/date and pulses come from logic on ref_clk_in.
 */
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps

module mfpc_front_panel #(
    parameter int MS_CYCLES = mfpc_pkg::MS_CYCLES_DEF
) (
    input wire logic ref_clk_in, // 100 MHz clock
    input wire logic rst_in, // async reset, active high
    input wire logic btn_up_in, // up arrow pin
    input wire logic btn_down_in, // down arrow pin
    input wire logic mode_enter_button_in, // mode/enter pin
    input wire logic btn_demand_reset_in, // demand reset switch pin
    input wire logic btn_test_in, // test mode button pin
    input wire logic btn_master_reset_in, // recessed master reset pin
    input wire logic [7:0] addr_in, // register byte address
    input wire logic [31:0] wr_data_in, // register write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    output logic [31:0] rd_data_out, // read data, cycle after strobe
    input wire logic active_pulse_in, // active energy pulse request
    input wire logic reactive_pulse_in, // reactive energy pulse request
    output logic led_active_out, // active energy led
    output logic ir_active_out, // active energy infrared
    output logic led_reactive_out, // reactive energy led
    output logic ir_reactive_out, // reactive energy infrared
    input wire logic [16:0] time_in, // hour[16:12] min[11:6] sec[5:0]
    input wire logic [15:0] date_in, // packed date
    input wire logic [2:0] phases_in, // phases present
    input wire logic [1:0] quadrant_in, // power factor quadrant
    input wire logic [15:0] interval_left_in, // demand interval seconds
    input wire logic [127:0] slot_raw_in, // four 32-bit raw values
    input wire logic [3:0] slot_valid_in, // value available per slot
    input wire logic [3:0] slot_meter_src_in, // value solely from meter
    output logic [16:0] status_time_out, // 24 hour time
    output logic [15:0] status_date_out, // date
    output logic [2:0] status_phases_out, // phases present
    output logic [1:0] status_quadrant_out, // quadrant
    output logic [1:0] status_mode_out, // mode code
    output logic [15:0] status_interval_out, // interval remaining
    output logic interval_end_indication_out, // interval counted out
    output logic [127:0] slot_value_out, // four scaled values
    output logic [7:0] slot_prefix_out, // two prefix bits per slot
    output logic [3:0] slot_na_out, // no-value marker per slot
    output logic [7:0] screen_out, // current screen index
    output logic scroll_active_out, // automatic scrolling running
    output logic [5:0] contrast_out, // display contrast
    output logic setup_open_out, // pulse: open setup menu
    output logic peak_demand_clear_out, // pulse: clear peak demand
    output logic test_demand_clear_out, // pulse: clear test demand
    output logic test_regs_clear_out, // pulse: clear test registers
    output logic master_clear_out, // pulse: master reset
    output logic billing_accum_en_out, // billing accumulation on
    output logic test_accum_en_out // test accumulation on
);

    localparam int NB = mfpc_pkg::NUM_BTN;

    typedef struct packed {
        logic [NB-1:0] sync1;
        logic [NB-1:0] sync2;
        logic [NB-1:0] stable;
        logic [NB-1:0] prev;
        logic [NB-1:0][3:0] deb_cnt;
        logic [mfpc_pkg::MS_CNT_W-1:0] ms_cnt;
        logic [9:0] sec_ms;
        logic [31:0] lock_cnt;
        logic [8:0] idle_sec;
        logic [7:0] dwell_sec;
        logic [11:0] hold_ms;
        logic hold_long;
        logic [7:0] contrast_ms;
        mfpc_pkg::mfpc_mode_t mode;
        logic [7:0] screen;
        logic suspended;
        logic [5:0] contrast;
        logic setup_open;
        logic peak_clr;
        logic test_dem_clr;
        logic test_clr;
        logic master_clr;
        logic led_act;
        logic led_react;
        logic [16:0] stime;
        logic [15:0] sdate;
        logic [2:0] sphases;
        logic [1:0] squad;
        logic [15:0] sinterval;
        logic seoi;
        logic [3:0][31:0] slot_val;
        logic [3:0][1:0] slot_pfx;
        logic [3:0] slot_na;
        logic auto_scale;
        logic units_default;
        logic [31:0] lockout;
        logic [7:0] screen_count;
        logic [7:0] dwell;
        logic [15:0] ratio;
        logic [31:0] rdata;
    } mfpc_state_t;

    mfpc_state_t st;
    mfpc_state_t next_st;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic [NB-1:0] raw;
        logic [NB-1:0] press;
        logic [NB-1:0] release_ev;
        logic ms_tick;
        logic sec_tick;
        logic any_press;
        logic both_held;
        logic [7:0] last_screen;
        logic [47:0] prod;
        raw = '0;
        press = '0;
        release_ev = '0;
        ms_tick = 1'b0;
        sec_tick = 1'b0;
        any_press = 1'b0;
        both_held = 1'b0;
        last_screen = '0;
        prod = '0;
        next_st = st;

        // one-cycle outputs drop unless raised below
        next_st.setup_open = 1'b0;
        next_st.peak_clr = 1'b0;
        next_st.test_dem_clr = 1'b0;
        next_st.test_clr = 1'b0;
        next_st.master_clr = 1'b0;

        // millisecond and second enables from one divider chain
        ms_tick = (st.ms_cnt == mfpc_pkg::MS_CNT_W'(MS_CYCLES - 1));
        next_st.ms_cnt = ms_tick ? '0 : st.ms_cnt + 1'b1;
        sec_tick = ms_tick && (st.sec_ms == mfpc_pkg::MS_PER_SEC - 10'd1);
        if (ms_tick) begin
            next_st.sec_ms = sec_tick ? '0 : st.sec_ms + 10'd1;
        end

        // two-flop synchronisers, then a debounce over a full window
        raw = {btn_master_reset_in, btn_test_in, btn_demand_reset_in,
               mode_enter_button_in, btn_down_in, btn_up_in};
        next_st.sync1 = raw;
        next_st.sync2 = st.sync1;
        for (int i = 0; i < NB; i++) begin
            if (st.sync2[i] == st.stable[i]) begin
                next_st.deb_cnt[i] = '0;
            end else if (ms_tick) begin
                if (st.deb_cnt[i] == mfpc_pkg::DEBOUNCE_MS - 4'd1) begin
                    next_st.stable[i] = st.sync2[i];
                    next_st.deb_cnt[i] = '0;
                end else begin
                    next_st.deb_cnt[i] = st.deb_cnt[i] + 4'd1;
                end
            end
        end
        next_st.prev = st.stable;
        press = st.stable & ~st.prev;
        release_ev = ~st.stable & st.prev;
        any_press = |press[mfpc_pkg::BTN_ENTER:mfpc_pkg::BTN_UP];
        both_held = st.stable[mfpc_pkg::BTN_UP] &&
                    st.stable[mfpc_pkg::BTN_DOWN];

        // idle time since the last navigation press
        if (any_press) begin
            next_st.idle_sec = '0;
        end else if (sec_tick && st.idle_sec != '1) begin
            next_st.idle_sec = st.idle_sec + 9'd1;
        end

        // screen stepping; a two-button hold is contrast, not a step
        last_screen = (st.screen_count == '0) ? '0
                      : st.screen_count - 8'd1;
        if (press[mfpc_pkg::BTN_UP] && !st.stable[mfpc_pkg::BTN_DOWN]) begin
            next_st.screen = (st.screen == '0) ? last_screen
                             : st.screen - 8'd1;
        end else if (press[mfpc_pkg::BTN_DOWN] &&
                     !st.stable[mfpc_pkg::BTN_UP]) begin
            next_st.screen = (st.screen >= last_screen) ? '0
                             : st.screen + 8'd1;
        end else if (!st.suspended && sec_tick) begin
            if (st.dwell_sec + 8'd1 >= st.dwell) begin
                next_st.dwell_sec = '0;
                next_st.screen = (st.screen >= last_screen) ? '0
                                 : st.screen + 8'd1;
            end else begin
                next_st.dwell_sec = st.dwell_sec + 8'd1;
            end
        end

        // scrolling pauses on any navigation press and resumes after idle time
        if (any_press) begin
            next_st.suspended = 1'b1;
            next_st.dwell_sec = '0;
        end else if (st.idle_sec >= mfpc_pkg::SCROLL_RESUME_S) begin
            next_st.suspended = 1'b0;
        end

        // contrast keeps stepping while both arrows stay down
        if (!both_held) begin
            next_st.contrast_ms = '0;
        end else if (ms_tick) begin
            if (st.contrast_ms == mfpc_pkg::CONTRAST_STEP_MS - 8'd1) begin
                next_st.contrast_ms = '0;
                next_st.contrast = st.contrast + 6'd1;
            end else begin
                next_st.contrast_ms = st.contrast_ms + 8'd1;
            end
        end

        // enter button: short press toggles, long hold opens setup
        if (press[mfpc_pkg::BTN_ENTER]) begin
            next_st.hold_ms = '0;
            next_st.hold_long = 1'b0;
        end else if (st.stable[mfpc_pkg::BTN_ENTER] && ms_tick &&
                     !st.hold_long) begin
            if (st.hold_ms == mfpc_pkg::HOLD_SETUP_MS - 12'd1) begin
                next_st.hold_long = 1'b1;
                next_st.setup_open = 1'b1;
            end else begin
                next_st.hold_ms = st.hold_ms + 12'd1;
            end
        end

        // mode machine; test mode ignores the enter toggle
        unique case (st.mode)
            mfpc_pkg::MFPC_NORMAL: begin
                if (press[mfpc_pkg::BTN_TEST]) begin
                    next_st.mode = mfpc_pkg::MFPC_TEST;
                end else if (release_ev[mfpc_pkg::BTN_ENTER] &&
                             !st.hold_long) begin
                    next_st.mode = mfpc_pkg::MFPC_ALTERNATE;
                end
            end
            mfpc_pkg::MFPC_ALTERNATE: begin
                if (press[mfpc_pkg::BTN_TEST]) begin
                    next_st.mode = mfpc_pkg::MFPC_TEST;
                end else if (release_ev[mfpc_pkg::BTN_ENTER] &&
                             !st.hold_long) begin
                    next_st.mode = mfpc_pkg::MFPC_NORMAL;
                end else if (st.idle_sec >= mfpc_pkg::ALT_TIMEOUT_S) begin
                    next_st.mode = mfpc_pkg::MFPC_NORMAL;
                end
            end
            mfpc_pkg::MFPC_TEST: begin
                if (press[mfpc_pkg::BTN_TEST]) begin
                    next_st.mode = mfpc_pkg::MFPC_NORMAL;
                    next_st.test_clr = 1'b1;
                end
            end
            default: begin
                next_st.mode = mfpc_pkg::MFPC_NORMAL;
            end
        endcase

        // demand reset with a saturating lockout timer
        if (press[mfpc_pkg::BTN_DEMAND] && st.lock_cnt >= st.lockout) begin
            next_st.lock_cnt = '0;
            if (st.mode == mfpc_pkg::MFPC_TEST) begin
                next_st.test_dem_clr = 1'b1;
            end else begin
                next_st.peak_clr = 1'b1;
            end
        end else if (sec_tick && st.lock_cnt != '1) begin
            next_st.lock_cnt = st.lock_cnt + 32'd1;
        end

        next_st.master_clr = press[mfpc_pkg::BTN_MASTER];

        // pulsers: led and infrared share one flop so rates match
        next_st.led_act = active_pulse_in;
        next_st.led_react = reactive_pulse_in;

        // status bar fields
        next_st.stime = time_in;
        next_st.sdate = date_in;
        next_st.sphases = phases_in;
        next_st.squad = quadrant_in;
        next_st.sinterval = interval_left_in;
        next_st.seoi = (interval_left_in == '0);

        // numeric slots; a 48-bit product costs area but never overflows
        for (int i = 0; i < mfpc_pkg::NUM_SLOTS; i++) begin
            prod = {16'h0000, slot_raw_in[i*32 +: 32]} * {32'h0, st.ratio};
            next_st.slot_na[i] = !slot_valid_in[i];
            next_st.slot_pfx[i] = mfpc_pkg::PFX_NONE;
            next_st.slot_val[i] = slot_raw_in[i*32 +: 32];
            if (!slot_valid_in[i]) begin
                next_st.slot_val[i] = '0;
            end else if (st.auto_scale && st.units_default &&
                         slot_meter_src_in[i]) begin
                if (prod >= mfpc_pkg::GIGA) begin
                    next_st.slot_val[i] = 32'(prod / mfpc_pkg::GIGA);
                    next_st.slot_pfx[i] = mfpc_pkg::PFX_GIGA;
                end else if (prod >= mfpc_pkg::MEGA) begin
                    next_st.slot_val[i] = 32'(prod / mfpc_pkg::MEGA);
                    next_st.slot_pfx[i] = mfpc_pkg::PFX_MEGA;
                end else if (prod >= mfpc_pkg::KILO) begin
                    next_st.slot_val[i] = 32'(prod / mfpc_pkg::KILO);
                    next_st.slot_pfx[i] = mfpc_pkg::PFX_KILO;
                end else begin
                    next_st.slot_val[i] = prod[31:0];
                end
            end
        end

        // register writes
        if (wr_in) begin
            unique case (addr_in)
                mfpc_pkg::REG_CTRL: begin
                    next_st.auto_scale = wr_data_in[mfpc_pkg::CTRL_AUTO_BIT];
                    next_st.units_default =
                        wr_data_in[mfpc_pkg::CTRL_UNITS_BIT];
                end
                mfpc_pkg::REG_LOCKOUT: next_st.lockout = wr_data_in;
                mfpc_pkg::REG_SCROLL: begin
                    next_st.screen_count = wr_data_in[7:0];
                    next_st.dwell = wr_data_in[15:8];
                end
                mfpc_pkg::REG_RATIO: next_st.ratio = wr_data_in[15:0];
                default: begin
                end
            endcase
        end

        // register reads, answered the cycle after the strobe
        next_st.rdata = '0;
        if (rd_in) begin
            unique case (addr_in)
                mfpc_pkg::REG_CTRL:
                    next_st.rdata = {30'h0, st.units_default, st.auto_scale};
                mfpc_pkg::REG_LOCKOUT: next_st.rdata = st.lockout;
                mfpc_pkg::REG_SCROLL:
                    next_st.rdata = {16'h0, st.dwell, st.screen_count};
                mfpc_pkg::REG_RATIO: next_st.rdata = {16'h0, st.ratio};
                mfpc_pkg::REG_STATUS:
                    next_st.rdata = {8'h0, 2'h0, st.contrast, st.screen,
                                     5'h0, st.suspended, st.mode};
                mfpc_pkg::REG_ELAPSED: next_st.rdata = st.lock_cnt;
                default: next_st.rdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; lockout starts saturated so a first reset is taken
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st <= '0;
            st.mode <= mfpc_pkg::MFPC_NORMAL;
            st.lock_cnt <= '1;
            st.lockout <= mfpc_pkg::LOCKOUT_DEF_S;
            st.screen_count <= mfpc_pkg::SCREEN_COUNT_DEF;
            st.dwell <= mfpc_pkg::DWELL_DEF_S;
            st.ratio <= mfpc_pkg::RATIO_DEF;
            st.contrast <= mfpc_pkg::CONTRAST_DEF;
            st.auto_scale <= 1'b1;
            st.units_default <= 1'b1;
            st.seoi <= 1'b1;
            st.slot_na <= '1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign rd_data_out = st.rdata;
    assign led_active_out = st.led_act;
    assign ir_active_out = st.led_act;
    assign led_reactive_out = st.led_react;
    assign ir_reactive_out = st.led_react;
    assign status_time_out = st.stime;
    assign status_date_out = st.sdate;
    assign status_phases_out = st.sphases;
    assign status_quadrant_out = st.squad;
    assign status_mode_out = st.mode;
    assign status_interval_out = st.sinterval;
    assign interval_end_indication_out = st.seoi;
    assign slot_value_out = st.slot_val;
    assign slot_prefix_out = st.slot_pfx;
    assign slot_na_out = st.slot_na;
    assign screen_out = st.screen;
    assign scroll_active_out = !st.suspended;
    assign contrast_out = st.contrast;
    assign setup_open_out = st.setup_open;
    assign peak_demand_clear_out = st.peak_clr;
    assign test_demand_clear_out = st.test_dem_clr;
    assign test_regs_clear_out = st.test_clr;
    assign master_clear_out = st.master_clr;
    // accumulation steering follows the mode directly
    assign billing_accum_en_out = (st.mode != mfpc_pkg::MFPC_TEST);
    assign test_accum_en_out = (st.mode == mfpc_pkg::MFPC_TEST);

endmodule : mfpc_front_panel

// ---- mfpc_pkg.sv ----
/*
 * Shared constants for the meter front panel control block: button
 * indices, mode codes, register map, reset values and timing figures.
 * Assumes a single 100 MHz clock and a plain byte-addressed register port.
 */
package mfpc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
    localparam int MS_CNT_W = 17;
    localparam logic [9:0] MS_PER_SEC = 10'd1000;
    localparam logic [3:0] DEBOUNCE_MS = 4'd10;
    localparam logic [11:0] HOLD_SETUP_MS = 12'd3000;
    localparam logic [7:0] CONTRAST_STEP_MS = 8'd200;
    localparam logic [8:0] SCROLL_RESUME_S = 9'd60;
    localparam logic [8:0] ALT_TIMEOUT_S = 9'd300;

    ////////////////////////////////////////////////////////////////////////
    // button indices
    localparam int NUM_BTN = 6;
    localparam int BTN_UP = 0;
    localparam int BTN_DOWN = 1;
    localparam int BTN_ENTER = 2;
    localparam int BTN_DEMAND = 3;
    localparam int BTN_TEST = 4;
    localparam int BTN_MASTER = 5;

    ////////////////////////////////////////////////////////////////////////
    // display modes, gray coded along normal -> alternate -> test
    typedef enum logic [1:0] {
        MFPC_NORMAL = 2'b00,
        MFPC_ALTERNATE = 2'b01,
        MFPC_TEST = 2'b11
    } mfpc_mode_t;

    ////////////////////////////////////////////////////////////////////////
    // register map (byte addresses) and reset values
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LOCKOUT = 8'h04;
    localparam logic [7:0] REG_SCROLL = 8'h08;
    localparam logic [7:0] REG_RATIO = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_ELAPSED = 8'h14;
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_UNITS_BIT = 1;
    localparam logic [31:0] LOCKOUT_DEF_S = 32'h0020_f580;
    localparam logic [7:0] SCREEN_COUNT_DEF = 8'h08;
    localparam logic [7:0] DWELL_DEF_S = 8'h05;
    localparam logic [15:0] RATIO_DEF = 16'h0001;
    localparam logic [5:0] CONTRAST_DEF = 6'h20;

    ////////////////////////////////////////////////////////////////////////
    // numeric display
    localparam int NUM_SLOTS = 4;
    localparam logic [47:0] PREFIX_STEP = 48'h0000_0000_03e8;
    localparam logic [47:0] KILO = PREFIX_STEP;
    localparam logic [47:0] MEGA = 48'h0000_000f_4240;
    localparam logic [47:0] GIGA = 48'h0000_3b9a_ca00;
    localparam logic [1:0] PFX_NONE = 2'h0;
    localparam logic [1:0] PFX_KILO = 2'h1;
    localparam logic [1:0] PFX_MEGA = 2'h2;
    localparam logic [1:0] PFX_GIGA = 2'h3;

endpackage : mfpc_pkg

// ---- mfpc_properties.sv ----
/* assertions on the front panel ports, bound into mfpc_front_panel;
   one clock, asynchronous active-high reset */
`timescale 1ns/1ps
module mfpc_properties (
    input wire logic ref_clk_in, // clock
    input wire logic rst_in, // reset
    input wire logic active_pulse_in, // pulse in
    input wire logic led_active_out, // led
    input wire logic ir_active_out, // infrared
    input wire logic [3:0] slot_valid_in, // present
    input wire logic [3:0] slot_na_out, // no value
    input wire logic peak_demand_clear_out, // clear
    input wire logic test_demand_clear_out, // clear
    input wire logic test_regs_clear_out, // clear
    input wire logic [1:0] status_mode_out, // mode
    input wire logic billing_accum_en_out, // billing
    input wire logic test_accum_en_out // test
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // led and infrared share one flop, so any drift is a wiring fault
    a_ir_same_led: assert property (ir_active_out == led_active_out)
        else $error("ir differs from led");
    a_led_follows: assert property (
        $rose(active_pulse_in) |=> led_active_out) else $error("led late");
    a_na_marker: assert property (
        1'b1 |=> slot_na_out == ~$past(slot_valid_in)) else $error("na bad");
    a_peak_outside: assert property (
        peak_demand_clear_out |-> $past(status_mode_out) != 2'b11)
        else $error("peak clear in test");
    a_test_demand: assert property (
        test_demand_clear_out |-> $past(status_mode_out) == 2'b11)
        else $error("test clear outside test");
    a_accum_split: assert property (
        billing_accum_en_out == (status_mode_out != 2'b11) &&
        test_accum_en_out != billing_accum_en_out) else $error("accum");
    a_exit_normal: assert property (
        test_regs_clear_out |-> status_mode_out == 2'b00 &&
        $past(status_mode_out) == 2'b11) else $error("test exit");
    a_clear_once: assert property (
        peak_demand_clear_out |=> !peak_demand_clear_out [*2])
        else $error("peak clear repeated");
    c_peak: cover property (peak_demand_clear_out);
    c_test: cover property (test_demand_clear_out);
    c_exit: cover property (test_regs_clear_out);
endmodule : mfpc_properties

bind mfpc_front_panel mfpc_properties u_props (.ref_clk_in, .rst_in,
    .active_pulse_in, .led_active_out, .ir_active_out, .slot_valid_in,
    .slot_na_out, .peak_demand_clear_out, .test_demand_clear_out,
    .test_regs_clear_out, .status_mode_out, .billing_accum_en_out,
    .test_accum_en_out);

// ---- mfpc_operator.sv ----
/* operator at the panel buttons, pins active high;
   assumes the panel clock and millisecond tick length */
`timescale 1ns/1ps
module mfpc_operator #(
    parameter int MS_CYCLES = 4
) (
    input wire logic ref_clk_in, // panel clock
    output logic [5:0] btn_out // pressed = 1
);
    initial btn_out = 6'h0;
    // hold then stay off 25 ms, past the debounce window
    task automatic press(input logic [5:0] mask, input int ms);
        @(posedge ref_clk_in) btn_out <= mask;
        repeat (ms * MS_CYCLES) @(posedge ref_clk_in);
        btn_out <= 6'h0;
        repeat (25 * MS_CYCLES) @(posedge ref_clk_in);
        #1;
    endtask : press
endmodule : mfpc_operator

// ---- test_meter_front_panel_control.sv ----
/* self-checking bench for mfpc_front_panel with a short ms tick;
   assumes mfpc_properties is bound and mfpc_operator drives pins */
`timescale 1ns/1ps
module test_meter_front_panel_control;
    localparam int MSC = 4;
    logic ref_clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic active_pulse_in = 1'b0;
    logic [7:0] addr_in = 8'h0, screen_out, slot_prefix_out;
    logic [31:0] wr_data_in = 32'h0, rd_data_out;
    logic [15:0] interval_left_in = 16'h0;
    logic [127:0] slot_value_out;
    logic interval_end_indication_out;
    logic [3:0] slot_valid_in = 4'h0, slot_na_out;
    logic [5:0] btn, contrast_out;
    logic [1:0] status_mode_out;
    logic led_active_out, ir_active_out, scroll_active_out, setup_open_out;
    logic peak_demand_clear_out, test_demand_clear_out, test_regs_clear_out;
    logic master_clear_out, billing_accum_en_out, test_accum_en_out;
    int fails = 0, n_compared = 0, n_pk = 0, n_td = 0, n_tr = 0;
    int n_su = 0, n_mc = 0;
    mfpc_operator #(.MS_CYCLES(MSC)) u_op (.ref_clk_in, .btn_out(btn));
    mfpc_front_panel #(.MS_CYCLES(MSC)) u_dut (.ref_clk_in, .rst_in,
        .btn_up_in(btn[0]), .btn_down_in(btn[1]),
        .mode_enter_button_in(btn[2]), .btn_demand_reset_in(btn[3]),
        .btn_test_in(btn[4]), .btn_master_reset_in(btn[5]), .addr_in,
        .wr_data_in, .wr_in, .rd_in, .rd_data_out, .active_pulse_in,
        .reactive_pulse_in(active_pulse_in), .led_active_out, .ir_active_out,
        .led_reactive_out(), .ir_reactive_out(), .interval_left_in,
        .time_in({1'b0, interval_left_in}), .date_in(interval_left_in),
        .phases_in(interval_left_in[2:0]), .quadrant_in(interval_left_in[1:0]),
        .slot_raw_in({4{wr_data_in}}), .slot_valid_in, .status_mode_out,
        .slot_meter_src_in(slot_valid_in), .status_time_out(),
        .status_date_out(), .status_phases_out(), .status_quadrant_out(),
        .status_interval_out(), .interval_end_indication_out,
        .slot_value_out, .slot_prefix_out, .slot_na_out, .screen_out,
        .scroll_active_out, .contrast_out, .setup_open_out,
        .peak_demand_clear_out, .test_demand_clear_out, .test_regs_clear_out,
        .master_clear_out, .billing_accum_en_out, .test_accum_en_out);
    // clock and pulse tallies; pulses last one cycle so each counts once
    always #5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        n_pk += peak_demand_clear_out;
        n_td += test_demand_clear_out;
        n_tr += test_regs_clear_out;
        n_su += setup_open_out;
        n_mc += master_clear_out;
    end
    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in) {addr_in, wr_data_in, wr_in} <= {a, d, 1'b1};
        @(posedge ref_clk_in) wr_in <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_in) {addr_in, rd_in} <= {a, 1'b1};
        @(posedge ref_clk_in) rd_in <= 1'b0;
        #1 chk("read", rd_data_out, exp);
    endtask : rd
    task automatic wrap_up;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // second demand press inside one second is refused, after it accepted
    task automatic t_demand;
        rd(8'hfc, 32'h0);
        wr(8'h04, 32'h1);
        u_op.press(6'h08, 20);
        u_op.press(6'h08, 20);
        chk("peak", n_pk, 1);
        rd(8'h14, 32'h0);
        repeat (MSC * 1000) @(posedge ref_clk_in);
        u_op.press(6'h08, 20);
        chk("peak", n_pk, 2);
    endtask : t_demand
    // short press toggles, a long hold opens setup and leaves the mode
    task automatic t_modes;
        u_op.press(6'h04, 20);
        chk("mode", status_mode_out, 32'h1);
        u_op.press(6'h04, 3100);
        chk("setup", n_su, 1);
        chk("mode", status_mode_out, 32'h1);
        u_op.press(6'h04, 20);
        chk("mode", status_mode_out, 32'h0);
    endtask : t_modes
    task automatic t_test;
        wr(8'h04, 32'h0);
        u_op.press(6'h10, 20);
        chk("mode", status_mode_out, 32'h3);
        chk("billing", billing_accum_en_out, 32'h0);
        u_op.press(6'h08, 20);
        chk("test", n_td + 4 * n_pk, 9);
        u_op.press(6'h10, 20);
        chk("regs", n_tr, 1);
        chk("mode", status_mode_out, 32'h0);
    endtask : t_test
    task automatic t_panel;
        logic [7:0] s;
        s = screen_out;
        u_op.press(6'h01, 20);
        chk("scroll", scroll_active_out, 32'h0);
        chk("screen", screen_out, (s + 8'h7) & 8'h7);
        u_op.press(6'h03, 450);
        chk("contrast", contrast_out, 32'h22);
        u_op.press(6'h20, 20);
        chk("master", n_mc, 1);
        @(posedge ref_clk_in) {active_pulse_in, slot_valid_in} <= 5'h15;
        {interval_left_in, wr_data_in} <= {16'h1234, 32'h001e_8480};
        @(posedge ref_clk_in) active_pulse_in <= 1'b0;
        #1 chk("ir", ir_active_out, 32'h1);
        chk("na", slot_na_out, 32'ha);
        chk("eoi", interval_end_indication_out, 32'h0);
        chk("pfx", {slot_prefix_out, slot_value_out[7:0]}, 32'h2202);
    endtask : t_panel
    initial begin
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        #1 chk("mode", status_mode_out, 32'h0);
        rd(8'h04, 32'h0020_f580);
        t_demand();
        t_modes();
        t_test();
        t_panel();
        wrap_up();
    end
    // run needs about 20k cycles; half a millisecond is a hang
    initial begin
        #500_000;
        fails++;
        wrap_up();
    end
endmodule : test_meter_front_panel_control
